// *** src/scan_cycle_pkg.sv ***
/*
  Constants, register map and carrier types for the scan cycle supervisor.
  Assumes a 200 MHz APB clock and an engine and I/O path on that clock.
*/
package scan_cycle_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_PERIOD_PS    = 5000;
  localparam int unsigned TICK_NS          = 100000;   // 0.1 ms
  localparam int unsigned PF_MIN_US        = 2000;     // 2 ms
  localparam int unsigned IMM_GAP_US       = 1300;     // 1.3 ms
  localparam int unsigned TICK_CYCLES_DEF  =
    (TICK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PF_CYCLES_DEF    =
    (PF_MIN_US * 1000 + CLK_PERIOD_PS / 1000 - 1) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned IMM_GAP_CYCLES_DEF =
    (IMM_GAP_US * 1000 + CLK_PERIOD_PS / 1000 - 1) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned TICKS_PER_MS     = 10;
  localparam int unsigned PCT_FULL         = 100;
  localparam logic [6:0]  SHARE_MAX        = 7'd99;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_PEAK      = 8'h00;
  localparam logic [7:0] OFF_CURRENT   = 8'h04;
  localparam logic [7:0] OFF_MIN       = 8'h08;
  localparam logic [7:0] OFF_MAX       = 8'h0c;
  localparam logic [7:0] OFF_SERIAL    = 8'h10;
  localparam logic [7:0] OFF_TOOL      = 8'h14;
  localparam logic [7:0] OFF_STATUS    = 8'h18;
  localparam logic [7:0] OFF_CONTROL   = 8'h1c;

  localparam logic [15:0] RST_MIN      = 16'h0000;
  localparam logic [15:0] RST_MAX      = 16'h0000;
  localparam logic [15:0] RST_SHARE    = 16'h0005;

  // status and control fields
  localparam int unsigned ST_RUN_BIT   = 0;
  localparam int unsigned ST_FATAL_BIT = 1;
  localparam int unsigned ST_PWR_BIT   = 2;
  localparam int unsigned ST_CODE_LSB  = 8;
  localparam int unsigned CTL_CLR_BIT  = 0;

  // fatal codes
  localparam logic [7:0] FATAL_NONE              = 8'h00;
  localparam logic [7:0] FATAL_CYCLE_OVER        = 8'h01;
  localparam logic [7:0] FATAL_INIT              = 8'h02;
  localparam logic [7:0] refresh_overrun_fatal_code = 8'h9f;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic init_done;
    logic init_error;
    logic exec_done;
    logic irq_req;
    logic irq_done;
    logic immediate_io_refresh;
    logic refresh_done;
  } ctrl_in_t;

  typedef struct packed {
    logic exec_run;
    logic irq_run;
    logic refresh_req;
    logic refresh_immediate;
    logic serial_service;
    logic tool_service;
    logic outputs_enable;
    logic power_down;
    logic fatal;
  } ctrl_out_t;

  typedef enum logic [3:0] {
    ST_INIT, ST_SUPERVISE, ST_EXEC, ST_IRQ, ST_IMM, ST_PAD, ST_REFRESH,
    ST_SERIAL, ST_TOOL, ST_HALT, ST_FATAL
  } phase_t;

endpackage : scan_cycle_pkg

// *** src/scan_cycle_supervisor.sv ***
/*
  Scan cycle supervisor: sequences the controller's repeating cycle, pads
  it to a minimum time, watches a maximum time, measures cycle times in
  0.1 ms units, and halts on a sustained supply drop.
  Assumes the engine and refresh path share pclk; supply_low is a raw pin
  from an 85 % voltage comparator and is synchronised here.
*/
// The placing of the registers and the APB slave port were left to the implementer.
// Behaviour
// - supply below 85 % rating halts the controller and forces outputs off
// - supply dips shorter than 2 ms are ignored and the cycle carries on
// - dips slightly over 2 ms may or may not be detected
// - a detected power loss stops execution and turns all outputs off
// - when the supply recovers above 85 % operation restarts by itself
// - after clean init loop supervise, execute, refresh, serve ports
// - keep peak and latest cycle time in 0.1 ms units
// - results go out at refresh; immediate refresh updates words at once
// - with a minimum set, idle after execution until it has elapsed
// - no idle when the cycle already exceeds the minimum
// - a cycle longer than a set maximum is fatal and stops operation
// - each port gets its share of cycle time, 5 % default, 0 to 99 %
// - an interrupt suspends the main program at once and runs its handler
// - interrupt handler time is counted into the cycle time
// - immediate refresh from main or handler lengthens the cycle time
// - cycle time spans execution, refresh and port servicing
`timescale 1ns/10ps
module scan_cycle_supervisor
  import scan_cycle_pkg::*;
#(
  parameter int unsigned TICK_CYCLES    = scan_cycle_pkg::TICK_CYCLES_DEF,
  parameter int unsigned PF_CYCLES      = scan_cycle_pkg::PF_CYCLES_DEF,
  parameter int unsigned IMM_GAP_CYCLES = scan_cycle_pkg::IMM_GAP_CYCLES_DEF
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire scan_cycle_pkg::apb_req_t  apb_req,
  output      scan_cycle_pkg::apb_rsp_t  apb_rsp,
  input  wire logic                    supply_low,
  input  wire scan_cycle_pkg::ctrl_in_t  ctrl_in,
  output      scan_cycle_pkg::ctrl_out_t ctrl_out
);

  // ==========================================================================
  // state
  typedef struct packed {
    phase_t      phase;
    logic [1:0]  sync;
    logic [19:0] tick_pre;
    logic [19:0] cycle_ticks;
    logic [23:0] svc_acc;
    logic [19:0] pf_cnt;
    logic [19:0] gap_cnt;
    logic        gap_armed;
    logic        ret_irq;
    logic [15:0] peak_cycle_time_word;
    logic [15:0] current_cycle_time_word;
    logic [15:0] min_cycle_setting;
    logic [15:0] max_cycle_setting;
    logic [15:0] serial_port_service_share;
    logic [15:0] tool_port_service_share;
    logic [7:0]  fatal_code;
    logic [31:0] prdata;
    ctrl_out_t   outs;
  } state_t;

  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);
  localparam logic [19:0] PF_LIMIT  = 20'(PF_CYCLES);
  localparam logic [19:0] GAP_LIMIT = 20'(IMM_GAP_CYCLES);

  state_t      s;
  state_t      next_s;
  logic        tick;
  logic        pf_hit;
  logic        wr;
  logic        setup;
  logic        mapped;
  logic [19:0] min_ticks;
  logic [19:0] max_ticks;
  logic [23:0] svc_goal;
  logic [6:0]  share_now;
  logic [31:0] rd_word;
  logic [15:0] status_word;

  // ==========================================================================
  // output decode, registered alongside the phase
  function automatic ctrl_out_t decode(input phase_t p,
                                       input logic    imm);
    ctrl_out_t o;
    o = '0;
    o.exec_run          = (p == ST_EXEC);
    o.irq_run           = (p == ST_IRQ);
    o.refresh_req       = (p == ST_REFRESH) || (p == ST_IMM);
    o.refresh_immediate = (p == ST_IMM);
    o.serial_service    = (p == ST_SERIAL);
    o.tool_service      = (p == ST_TOOL);
    o.outputs_enable    = (p != ST_INIT) && (p != ST_HALT) &&
                          (p != ST_FATAL) && !imm;
    o.power_down        = (p == ST_HALT);
    o.fatal             = (p == ST_FATAL);
    return o;
  endfunction : decode

  function automatic logic [6:0] clamp_share(input logic [15:0] v);
    clamp_share = (v > 16'(SHARE_MAX)) ? SHARE_MAX : v[6:0];
  endfunction : clamp_share

  // ==========================================================================
  // helpers
  assign tick      = (s.tick_pre == TICK_LAST);
  assign pf_hit    = (s.pf_cnt >= PF_LIMIT);
  assign min_ticks = 20'(s.min_cycle_setting * TICKS_PER_MS);
  assign max_ticks = 20'(s.max_cycle_setting * TICKS_PER_MS);
  assign share_now = (s.phase == ST_TOOL) ?
                     clamp_share(s.tool_port_service_share) :
                     clamp_share(s.serial_port_service_share);
  // budget in percent-ticks so no divider is needed
  assign svc_goal  = 24'(share_now) * 24'(s.current_cycle_time_word);
  assign setup     = apb_req.psel && !apb_req.penable;
  assign wr        = apb_req.psel && apb_req.penable && apb_req.pwrite;

  assign status_word = {s.fatal_code, 5'h00,
                        s.outs.power_down, s.outs.fatal,
                        s.outs.outputs_enable};

  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (apb_req.paddr)
      OFF_PEAK:    rd_word = {16'h0000, s.peak_cycle_time_word};
      OFF_CURRENT: rd_word = {16'h0000, s.current_cycle_time_word};
      OFF_MIN:     rd_word = {16'h0000, s.min_cycle_setting};
      OFF_MAX:     rd_word = {16'h0000, s.max_cycle_setting};
      OFF_SERIAL:  rd_word = {16'h0000, s.serial_port_service_share};
      OFF_TOOL:    rd_word = {16'h0000, s.tool_port_service_share};
      OFF_STATUS:  rd_word = {16'h0000, status_word};
      OFF_CONTROL: rd_word = 32'h0000_0000;
      default:     mapped  = 1'b0;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_s      = s;
    next_s.sync = {s.sync[0], supply_low};

    // 0.1 ms time base and cycle counter, running through every phase
    next_s.tick_pre = tick ? 20'h00000 : s.tick_pre + 20'h00001;
    if (tick && s.cycle_ticks != 20'hfffff) begin
      next_s.cycle_ticks = s.cycle_ticks + 20'h00001;
    end
    if (tick && (s.phase == ST_SERIAL || s.phase == ST_TOOL)) begin
      next_s.svc_acc = s.svc_acc + 24'(PCT_FULL);
    end

    // sustained low supply only; a short dip clears the count
    if (s.sync[1]) begin
      if (!pf_hit) begin
        next_s.pf_cnt = s.pf_cnt + 20'h00001;
      end
    end else begin
      next_s.pf_cnt = 20'h00000;
    end

    if (s.gap_armed && s.gap_cnt < GAP_LIMIT) begin
      next_s.gap_cnt = s.gap_cnt + 20'h00001;
    end

    // ------------------------------------------------------------------
    // sequencer
    unique case (s.phase)
      ST_INIT: begin
        if (ctrl_in.init_error) begin
          next_s.phase      = ST_FATAL;
          next_s.fatal_code = FATAL_INIT;
        end else if (ctrl_in.init_done) begin
          next_s.phase       = ST_SUPERVISE;
          next_s.cycle_ticks = 20'h00000;
          next_s.tick_pre    = 20'h00000;
        end
      end
      ST_SUPERVISE: begin
        next_s.phase = ST_EXEC;
      end
      ST_EXEC: begin
        if (ctrl_in.irq_req) begin
          next_s.phase = ST_IRQ;
        end else if (ctrl_in.immediate_io_refresh) begin
          next_s.phase   = ST_IMM;
          next_s.ret_irq = 1'b0;
        end else if (ctrl_in.exec_done) begin
          next_s.phase = ST_PAD;
        end
      end
      ST_IRQ: begin
        if (ctrl_in.immediate_io_refresh) begin
          // device-side guard for too-frequent refresh from a handler
          if (s.gap_armed && s.gap_cnt < GAP_LIMIT) begin
            next_s.phase      = ST_FATAL;
            next_s.fatal_code = refresh_overrun_fatal_code;
          end else begin
            next_s.phase     = ST_IMM;
            next_s.ret_irq   = 1'b1;
            next_s.gap_armed = 1'b1;
            next_s.gap_cnt   = 20'h00000;
          end
        end else if (ctrl_in.irq_done) begin
          next_s.phase = ST_EXEC;
        end
      end
      ST_IMM: begin
        if (ctrl_in.refresh_done) begin
          next_s.phase = s.ret_irq ? ST_IRQ : ST_EXEC;
        end
      end
      ST_PAD: begin
        // a zero setting or an already long cycle skips the pause
        if (s.min_cycle_setting == 16'h0000 ||
            s.cycle_ticks >= min_ticks) begin
          next_s.phase = ST_REFRESH;
        end
      end
      ST_REFRESH: begin
        if (ctrl_in.refresh_done) begin
          next_s.phase   = ST_SERIAL;
          next_s.svc_acc = 24'h000000;
        end
      end
      ST_SERIAL: begin
        if (s.svc_acc >= svc_goal) begin
          next_s.phase   = ST_TOOL;
          next_s.svc_acc = 24'h000000;
        end
      end
      ST_TOOL: begin
        if (s.svc_acc >= svc_goal) begin
          next_s.phase = ST_SUPERVISE;
          // word saturates; the internal count is wider
          next_s.current_cycle_time_word =
            (s.cycle_ticks > 20'h0ffff) ? 16'hffff
                                        : s.cycle_ticks[15:0];
          if (next_s.current_cycle_time_word > s.peak_cycle_time_word) begin
            next_s.peak_cycle_time_word =
              next_s.current_cycle_time_word;
          end
          next_s.cycle_ticks = 20'h00000;
          // whole ticks from cycle start, or the pause ends a tick early
          next_s.tick_pre    = 20'h00000;
        end
      end
      ST_HALT: begin
        if (!s.sync[1]) begin
          next_s.phase = ST_INIT;
        end
      end
      ST_FATAL: begin
        if (wr && apb_req.paddr == OFF_CONTROL &&
            apb_req.pwdata[CTL_CLR_BIT]) begin
          next_s.phase      = ST_INIT;
          next_s.fatal_code = FATAL_NONE;
        end
      end
    endcase

    // watchdog over the whole cycle while the loop is running
    if (s.phase != ST_INIT && s.phase != ST_HALT && s.phase != ST_FATAL &&
        s.max_cycle_setting != 16'h0000 && s.cycle_ticks > max_ticks) begin
      next_s.phase      = ST_FATAL;
      next_s.fatal_code = FATAL_CYCLE_OVER;
    end

    // power loss overrides everything except a fatal stop
    if (pf_hit && s.phase != ST_FATAL && s.phase != ST_HALT) begin
      next_s.phase     = ST_HALT;
      next_s.gap_armed = 1'b0;
    end

    // ------------------------------------------------------------------
    // register writes
    if (wr) begin
      unique case (apb_req.paddr)
        OFF_MIN:    next_s.min_cycle_setting = apb_req.pwdata[15:0];
        OFF_MAX:    next_s.max_cycle_setting = apb_req.pwdata[15:0];
        OFF_SERIAL: next_s.serial_port_service_share =
                      {9'h000, clamp_share(apb_req.pwdata[15:0])};
        OFF_TOOL:   next_s.tool_port_service_share =
                      {9'h000, clamp_share(apb_req.pwdata[15:0])};
        default: ;
      endcase
    end
    if (setup) begin
      next_s.prdata = rd_word;
    end

    // outputs forced off whenever the phase is stopped
    next_s.outs = decode(next_s.phase, 1'b0);
  end

  // ==========================================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s                           <= '0;
      s.phase                     <= ST_INIT;
      s.min_cycle_setting         <= RST_MIN;
      s.max_cycle_setting         <= RST_MAX;
      s.serial_port_service_share <= RST_SHARE;
      s.tool_port_service_share   <= RST_SHARE;
      s.fatal_code                <= FATAL_NONE;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // ports
  assign apb_rsp.prdata  = s.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable && !mapped;
  assign ctrl_out        = s.outs;

endmodule : scan_cycle_supervisor

// *** test/scan_cycle_supervisor_sva.sv ***
/*
  Checker: port timing of the scan cycle supervisor.
  Assumes it is bound onto scan_cycle_supervisor, one clock domain.
*/
`timescale 1ns/10ps
module scan_cycle_supervisor_sva
  import scan_cycle_pkg::*;
#(
  parameter int unsigned TICK_CYCLES    = scan_cycle_pkg::TICK_CYCLES_DEF,
  parameter int unsigned PF_CYCLES      = scan_cycle_pkg::PF_CYCLES_DEF,
  parameter int unsigned IMM_GAP_CYCLES = scan_cycle_pkg::IMM_GAP_CYCLES_DEF
) (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire scan_cycle_pkg::apb_req_t  apb_req,
  input wire scan_cycle_pkg::apb_rsp_t  apb_rsp,
  input wire logic                      supply_low,
  input wire scan_cycle_pkg::ctrl_in_t  ctrl_in,
  input wire scan_cycle_pkg::ctrl_out_t ctrl_out
);
  // ==========================================================================
  // helper
  int lowcnt;
  // saturates so a long outage cannot wrap back under the threshold
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lowcnt <= 0;
    else if (!supply_low) lowcnt <= 0;
    else if (lowcnt <= PF_CYCLES + 8) lowcnt <= lowcnt + 1;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // sequences
  sequence seq_scan_done;
    ctrl_out.exec_run && ctrl_in.exec_done && !ctrl_in.irq_req &&
      !ctrl_in.immediate_io_refresh;
  endsequence
  sequence seq_supply_back;
    ctrl_out.power_down && !supply_low ##1 !supply_low [*3];
  endsequence
  sequence seq_ports_done;
    $fell(ctrl_out.tool_service) && !ctrl_out.power_down && !ctrl_out.fatal;
  endsequence
  // ==========================================================================
  // assertions
  a_halt_outputs_off: assert property (lowcnt > PF_CYCLES + 6 |->
    ctrl_out.power_down && !ctrl_out.outputs_enable)
    else $error("outputs still on after long supply drop");
  a_no_short_halt: assert property ($rose(ctrl_out.power_down) |->
    lowcnt >= PF_CYCLES)
    else $error("power loss taken on a short dip");
  a_halt_all_stop: assert property (ctrl_out.power_down |->
    !(ctrl_out.exec_run || ctrl_out.irq_run || ctrl_out.refresh_req ||
      ctrl_out.outputs_enable))
    else $error("activity during power loss halt");
  a_auto_restart: assert property (seq_supply_back |=>
    !ctrl_out.power_down)
    else $error("no restart after supply returned");
  a_exec_to_pad: assert property (seq_scan_done |=>
    !ctrl_out.exec_run && !ctrl_out.irq_run)
    else $error("main program kept running after its end");
  a_irq_preempts: assert property (
    ctrl_out.exec_run && ctrl_in.irq_req |=>
      ctrl_out.irq_run && !ctrl_out.exec_run)
    else $error("interrupt did not suspend the main program");
  a_imm_refresh: assert property (
    ctrl_out.exec_run && ctrl_in.immediate_io_refresh && !ctrl_in.irq_req
      |=> ctrl_out.refresh_req && ctrl_out.refresh_immediate)
    else $error("immediate refresh not started");
  a_fatal_stops: assert property (ctrl_out.fatal |->
    !ctrl_out.outputs_enable && !ctrl_out.exec_run && !ctrl_out.irq_run)
    else $error("operation continues in fatal state");
  a_serial_then_tool: assert property (
    $fell(ctrl_out.serial_service) |->
      ctrl_out.tool_service || ctrl_out.power_down || ctrl_out.fatal)
    else $error("tool port window did not follow serial window");
  a_ports_then_exec: assert property (seq_ports_done |=>
    ctrl_out.exec_run || ctrl_out.power_down || ctrl_out.fatal)
    else $error("new cycle did not start after port service");
endmodule : scan_cycle_supervisor_sva

bind scan_cycle_supervisor scan_cycle_supervisor_sva #(
  .TICK_CYCLES(TICK_CYCLES), .PF_CYCLES(PF_CYCLES),
  .IMM_GAP_CYCLES(IMM_GAP_CYCLES)
) i_scan_cycle_supervisor_sva (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .supply_low(supply_low), .ctrl_in(ctrl_in), .ctrl_out(ctrl_out)
);

// *** test/io_refresh_model.sv ***
/*
  Partner: field I/O refresh path answering refresh requests.
  Assumes refresh_req is held until refresh_done has been seen.
*/
`timescale 1ns/10ps
module io_refresh_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic refresh_req,
  input  wire logic slow,
  output logic      refresh_done
);
  // ==========================================================================
  // responder
  int cnt;
  // slow mode stalls the path to stretch the refresh phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      refresh_done <= 1'b0;
    end else begin
      refresh_done <= 1'b0;
      if (!refresh_req || refresh_done) begin
        cnt <= 0;
      end else if (cnt >= (slow ? 12 : 1)) begin
        refresh_done <= 1'b1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : io_refresh_model

// *** test/tb_top.sv ***
/*
  Bench: APB and engine stimulus for the scan cycle supervisor.
  Assumes io_refresh_model on the refresh side and the bound checker.
*/
`timescale 1ns/10ps
module tb_top;
  import scan_cycle_pkg::*;
  // ==========================================================================
  // signals
  localparam int EXE = 8;
  localparam int RFQ = 6;
  localparam int RIM = 5;
  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        supply_low  = 1'b0;
  logic        slow        = 1'b0;
  logic [5:0]  eng         = '0;
  apb_req_t    req         = '0;
  int          mismatches  = 0;
  int          comparisons = 0;
  int          cyc         = 0;
  int          pk          = 0;
  logic        rdone;
  logic        err;
  logic [31:0] q;
  apb_rsp_t    rsp;
  ctrl_in_t    ci;
  ctrl_out_t   co;
  int          t_rise;
  int          len;
  int          gap;
  assign ci = {eng, rdone};
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  scan_cycle_supervisor #(
    .TICK_CYCLES(10), .PF_CYCLES(40), .IMM_GAP_CYCLES(30)
  ) i_scan_cycle_supervisor (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .supply_low(supply_low), .ctrl_in(ci), .ctrl_out(co)
  );
  io_refresh_model i_io_refresh_model (
    .pclk(pclk), .presetn(presetn), .refresh_req(co.refresh_req),
    .slow(slow), .refresh_done(rdone)
  );
  // ==========================================================================
  // tasks
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    // no fixed limit: only the watchdog ends a stalled access
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    q = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd
  task wait_out(input int b, input logic v);
    int k;
    for (k = 0; k < 5000 && co[b] !== v; k++) @(posedge pclk);
  endtask : wait_out
  // engine bits: init_done 5, exec_done 3, irq_req 2, irq_done 1, imm 0
  task pulse(input int b);
    @(posedge pclk);
    eng[b] <= 1'b1;
    @(posedge pclk);
    eng[b] <= 1'b0;
  endtask : pulse
  task scan(input int ex, input int irq, input logic imm);
    int t1;
    repeat (ex) @(posedge pclk);
    if (irq > 0) begin
      pulse(2);
      repeat (irq) @(posedge pclk);
      pulse(1);
    end
    if (imm) begin
      pulse(0);
      wait_out(RIM, 1'b1);
      wait_out(RIM, 1'b0);
    end
    wait_out(EXE, 1'b1);
    pulse(3);
    t1 = cyc;
    wait_out(RFQ, 1'b1);
    gap = cyc - t1;
    wait_out(EXE, 1'b1);
    len = cyc - t_rise;
    t_rise = cyc;
    apb(1'b0, OFF_CURRENT, 32'h0);
    chk({31'h0, q * 10 <= len + 10 && q * 10 + 10 >= len}, 32'h1);
    if (q > pk) pk = int'(q);
    rd(OFF_PEAK, pk);
  endtask : scan
  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // ==========================================================================
  // tests
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_PEAK, 32'h0);
    rd(OFF_CURRENT, 32'h0);
    rd(OFF_MIN, {16'h0, RST_MIN});
    rd(OFF_MAX, {16'h0, RST_MAX});
    rd(OFF_TOOL, {16'h0, RST_SHARE});
    wr(OFF_SERIAL, 32'h78);
    rd(OFF_SERIAL, {25'h0, SHARE_MAX});
    wr(OFF_SERIAL, 32'h5);
    wr(OFF_TOOL, 32'h0);
    rd(OFF_TOOL, 32'h0);
    wr(OFF_PEAK, 32'h1234);
    rd(OFF_PEAK, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    pulse(5);
    wait_out(EXE, 1'b1);
    t_rise = cyc;
    scan(200, 0, 1'b0);
    scan(50, 0, 1'b0);
    slow <= 1'b1;
    scan(40, 100, 1'b1);
    slow <= 1'b0;
    scan(30, 0, 1'b1);
    wr(OFF_MIN, 32'h1);
    scan(10, 0, 1'b0);
    chk({31'h0, len >= 100}, 32'h1);
    scan(150, 0, 1'b0);
    chk({31'h0, gap <= 3}, 32'h1);
    wr(OFF_MIN, 32'h0);
    wr(OFF_MAX, 32'h1);
    repeat (150) @(posedge pclk);
    rd(OFF_STATUS, {16'h0, FATAL_CYCLE_OVER, 8'h02});
    wr(OFF_MAX, 32'h0);
    wr(OFF_CONTROL, 32'h1);
    pulse(5);
    wait_out(EXE, 1'b1);
    // two handler refreshes far too close together
    pulse(2);
    pulse(0);
    wait_out(RIM, 1'b1);
    wait_out(RIM, 1'b0);
    pulse(0);
    repeat (4) @(posedge pclk);
    rd(OFF_STATUS, {16'h0, refresh_overrun_fatal_code, 8'h02});
    wr(OFF_CONTROL, 32'h1);
    pulse(5);
    wait_out(EXE, 1'b1);
    supply_low <= 1'b1;
    repeat (20) @(posedge pclk);
    supply_low <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({31'h0, co.exec_run}, 32'h1);
    supply_low <= 1'b1;
    repeat (60) @(posedge pclk);
    chk({30'h0, co.power_down, co.outputs_enable}, 32'h2);
    supply_low <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({31'h0, co.power_down}, 32'h0);
    pulse(4);
    rd(OFF_STATUS, {16'h0, FATAL_INIT, 8'h02});
    wr(OFF_CONTROL, 32'h1);
    pulse(5);
    wait_out(EXE, 1'b1);
    chk({31'h0, co.exec_run}, 32'h1);
    summarize();
  end
  // about thirty times the expected run length
  initial begin
    #200000;
    mismatches++;
    summarize();
  end
endmodule : tb_top
